/* rtl/watchdog_timer.sv */
// watchdog timer: prescaled down-counter, feed sequence, reset and interrupt modes
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer
  import watchdog_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // count clock as a one-cycle tick
  input  wire logic             count_tick_i,
  // register writes from the processor
  input  wire logic             mode_wr_i,
  input  wire mode_t            mode_wdata_i,
  input  wire logic             tc_wr_i,
  input  wire logic [CNT_W-1:0] tc_wdata_i,
  input  wire logic             feed_wr_i,
  input  wire logic [7:0]       feed_wdata_i,
  input  wire logic             other_access_i,
  input  wire logic             timeout_flag_clr_i,
  // register state
  output logic                  run_enable_o,
  output logic                  reset_on_timeout_o,
  output logic      [CNT_W-1:0] timeout_constant_o,
  output logic      [CNT_W-1:0] count_readback_o,
  output logic                  timeout_flag_o,
  output logic                  timeout_irq_flag_o,
  // events
  output logic                  running_o,
  output logic                  chip_reset_o
);

  localparam int PW = $clog2(PRESCALE_DIV);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE_DIV - 1);

  initial begin
    if (CNT_W != 32 || PRESCALE_DIV < 2) begin
      $error("watchdog_timer: counter must be 32 bits and prescaler at least 2");
    end
  end

  function automatic logic feed_byte(input logic wr, input logic [7:0] data, input logic [7:0] val);
    feed_byte = wr && (data == val);
  endfunction

  // register-side state
  mode_t             mode,        next_mode;
  logic [CNT_W-1:0]  tc,          next_tc;
  feed_state_t       feed_state,  next_feed_state;
  logic              err_pend,    next_err_pend;
  // counting-side state
  logic              armed,       next_armed;
  logic [PW-1:0]     presc,       next_presc;
  logic [CNT_W-1:0]  count,       next_count;
  logic [CNT_W-1:0]  snap,        next_snap;
  logic              tof,         next_tof;
  logic              irqf,        next_irqf;
  logic              chip_reset,  next_chip_reset;

  ctrl_t             ctrl_eff;
  logic              feed_ok;
  logic              feed_bad;
  logic              tick_end;
  logic              fire;

  // control values reach the counting logic after three count ticks
  stage_delay #(
    .WIDTH  (CTRL_W),
    .STAGES (CTRL_STAGES)
  ) u_ctrl_sync (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .adv_i     (count_tick_i),
    .rst_val_i ({TC_RESET, MODE_RESET}),
    .d_i       ({tc, mode}),
    .q_o       (ctrl_eff)
  );

  // captured count passes two more registers before software sees it
  stage_delay #(
    .WIDTH  (CNT_W),
    .STAGES (READ_STAGES)
  ) u_read_sync (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .adv_i     (1'b1),
    .rst_val_i (COUNT_RESET),
    .d_i       (snap),
    .q_o       (count_readback_o)
  );

  always_comb begin
    feed_ok  = (feed_state == FEED_HALF) && feed_byte(feed_wr_i, feed_wdata_i, FEED_SECOND);
    feed_bad = (feed_state == FEED_HALF) && !feed_ok &&
               (feed_wr_i || mode_wr_i || tc_wr_i || other_access_i);
    tick_end = count_tick_i && (presc == PRESC_LAST);
    // a feed error fires one cycle after it is seen, i.e. on the second clock
    fire     = (armed && tick_end && (count == '0)) || err_pend;
  end

  // register side
  always_comb begin
    next_feed_state = feed_state;
    if (feed_ok || feed_bad) begin
      next_feed_state = FEED_IDLE;
    end else if (feed_byte(feed_wr_i, feed_wdata_i, FEED_FIRST)) begin
      next_feed_state = FEED_HALF;
    end
    next_err_pend = feed_bad && armed;

    next_mode = mode;
    if (fire) begin
      next_mode = MODE_RESET;
    end else if (mode_wr_i) begin
      // set-only bits: a zero written leaves the bit as it was
      next_mode = mode | mode_wdata_i;
    end

    next_tc = tc;
    if (tc_wr_i) begin
      next_tc = (tc_wdata_i < TC_MIN) ? TC_MIN : tc_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode       <= MODE_RESET;
      tc         <= TC_RESET;
      feed_state <= FEED_IDLE;
      err_pend   <= 1'b0;
    end else begin
      mode       <= next_mode;
      tc         <= next_tc;
      feed_state <= next_feed_state;
      err_pend   <= next_err_pend;
    end
  end

  // counting side
  always_comb begin
    next_armed = armed;
    if (fire) begin
      next_armed = 1'b0;
    end else if (feed_ok && ctrl_eff.mode.run_enable) begin
      next_armed = 1'b1;
    end

    next_presc = presc;
    next_count = count;
    if (feed_ok) begin
      next_presc = '0;
      next_count = ctrl_eff.tc;
    end else if (armed && count_tick_i) begin
      next_presc = (presc == PRESC_LAST) ? '0 : presc + PW'(1);
      if (tick_end) begin
        next_count = count - CNT_W'(1);
      end
    end

    next_snap = count_tick_i ? count : snap;

    next_chip_reset = fire && ctrl_eff.mode.reset_on_timeout;

    // a new reset-mode timeout wins over a clear in the same cycle
    next_tof = tof;
    if (fire && ctrl_eff.mode.reset_on_timeout) begin
      next_tof = 1'b1;
    end else if (timeout_flag_clr_i) begin
      next_tof = 1'b0;
    end

    next_irqf = irqf | (fire && !ctrl_eff.mode.reset_on_timeout);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      armed      <= 1'b0;
      presc      <= '0;
      count      <= COUNT_RESET;
      snap       <= COUNT_RESET;
      tof        <= 1'b0;
      irqf       <= 1'b0;
      chip_reset <= 1'b0;
    end else begin
      armed      <= next_armed;
      presc      <= next_presc;
      count      <= next_count;
      snap       <= next_snap;
      tof        <= next_tof;
      irqf       <= next_irqf;
      chip_reset <= next_chip_reset;
    end
  end

  assign run_enable_o       = mode.run_enable;
  assign reset_on_timeout_o = mode.reset_on_timeout;
  assign timeout_constant_o = tc;
  assign timeout_flag_o     = tof;
  assign timeout_irq_flag_o = irqf;
  assign running_o          = armed;
  assign chip_reset_o       = chip_reset;

endmodule

`default_nettype wire

/* rtl/watchdog_pkg.sv */
// constants and types shared by the watchdog timer design
package watchdog_pkg;

  // timeout counter and prescaler
  localparam int          CNT_W         = 32;
  localparam int          PRESCALE_DIV  = 4;
  localparam logic [31:0] TC_MIN        = 32'h0000_00ff;
  localparam logic [31:0] TC_RESET      = 32'h0000_00ff;
  localparam logic [31:0] COUNT_RESET   = 32'h0000_00ff;

  // crossing depths, counted in count-clock ticks and clock cycles
  localparam int          CTRL_STAGES   = 3;
  localparam int          READ_STAGES   = 2;

  // feed sequence bytes
  localparam logic [7:0]  FEED_FIRST    = 8'haa;
  localparam logic [7:0]  FEED_SECOND   = 8'h55;

  typedef struct packed {
    logic reset_on_timeout;
    logic run_enable;
  } mode_t;

  localparam mode_t       MODE_RESET    = 2'h0;

  // control values as seen by the counting logic
  typedef struct packed {
    logic [31:0] tc;
    mode_t       mode;
  } ctrl_t;

  localparam int          CTRL_W        = $bits(ctrl_t);

  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_HALF = 2'b10
  } feed_state_t;

endpackage

/* rtl/stage_delay.sv */
// delay line of registers that advances on an enable pulse
`timescale 1ns/1ps
`default_nettype none

module stage_delay #(
  parameter int WIDTH  = 8,
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // data path
  input  wire logic             adv_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  initial begin
    if (STAGES < 1 || WIDTH < 1) begin
      $error("stage_delay: STAGES and WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] stage      [STAGES];
  logic [WIDTH-1:0] next_stage [STAGES];

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      always_comb begin
        next_stage[g] = stage[g];
        if (adv_i) begin
          next_stage[g] = (g == 0) ? d_i : stage[(g == 0) ? 0 : g - 1];
        end
      end

      // reset value is a constant port tie at the instance
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          stage[g] <= rst_val_i;
        end else begin
          stage[g] <= next_stage[g];
        end
      end
    end
  endgenerate

  assign q_o = stage[STAGES-1];

endmodule

`default_nettype wire

/* bench/count_clock_src.sv */
// count clock source model: one tick pulse every PERIOD system clocks
`timescale 1ns/1ps
`default_nettype none
module count_clock_src #(
  parameter int PERIOD = 3
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // count clock as a tick enable
  output logic      tick_o
);
  int phase;
  initial tick_o = 1'b0;
  // count clock is derived from the register clock, not a separate source
  always @(posedge clk_i) begin
    phase <= (srst_i || phase == PERIOD - 1) ? 0 : phase + 1;
    tick_o <= #1 !srst_i && phase == PERIOD - 1;
  end
endmodule
`default_nettype wire

/* bench/watchdog_timer_props.sv */
// port assertions for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_props
  import watchdog_pkg::*;
(
  // clock, reset and requests
  input wire logic             clk_i, srst_i, tc_wr_i, feed_wr_i, other_access_i, timeout_flag_clr_i,
  input wire logic [CNT_W-1:0] tc_wdata_i,
  input wire logic [7:0]       feed_wdata_i,
  // state and events
  input wire logic             run_enable_o, reset_on_timeout_o, timeout_flag_o, timeout_irq_flag_o,
  input wire logic             running_o, chip_reset_o,
  input wire logic [CNT_W-1:0] timeout_constant_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence seq_half_feed;
    running_o && feed_wr_i && feed_wdata_i == FEED_FIRST;
  endsequence
  sequence seq_wrong_access;
    other_access_i && !feed_wr_i;
  endsequence
  a_tc_write_floor: assert property (tc_wr_i |=> timeout_constant_o ==
    (($past(tc_wdata_i) < TC_MIN) ? TC_MIN : $past(tc_wdata_i))) else $error("constant write wrong");
  a_run_set_only: assert property (!running_o && run_enable_o |=> run_enable_o)
    else $error("run enable cleared");
  a_feed_arms: assert property ($rose(running_o) |-> $past(feed_wr_i) &&
    $past(feed_wdata_i) == FEED_SECOND) else $error("armed without feed");
  a_chip_reset_pulse: assert property (chip_reset_o |-> timeout_flag_o ##1 !chip_reset_o)
    else $error("chip reset pulse wrong");
  a_reset_cause: assert property ($rose(chip_reset_o) |-> $past(running_o) &&
    $past(reset_on_timeout_o) && !running_o) else $error("chip reset without cause");
  a_irq_cause: assert property ($rose(timeout_irq_flag_o) |-> $past(running_o) &&
    !running_o && !chip_reset_o) else $error("irq flag without cause");
  a_irq_sticky: assert property (timeout_irq_flag_o |=> timeout_irq_flag_o)
    else $error("irq flag cleared");
  a_tof_clear: assert property (timeout_flag_clr_i |=> timeout_flag_o == chip_reset_o)
    else $error("timeout flag clear wrong");
  a_abort_fire: assert property (seq_half_feed ##1 seq_wrong_access |-> ##2 !running_o)
    else $error("abort did not fire");
endmodule
bind watchdog_timer watchdog_timer_props watchdog_timer_props_i (.clk_i, .srst_i, .tc_wr_i, .feed_wr_i,
  .other_access_i, .timeout_flag_clr_i, .tc_wdata_i, .feed_wdata_i, .run_enable_o, .reset_on_timeout_o,
  .timeout_flag_o, .timeout_irq_flag_o, .running_o, .chip_reset_o, .timeout_constant_o);
`default_nettype wire

/* bench/watchdog_timer_tb.sv */
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_tb
  import watchdog_pkg::*;
;
  logic             clk_i, srst_i, count_tick_i, mode_wr_i, tc_wr_i, feed_wr_i;
  logic             other_access_i, timeout_flag_clr_i, run_enable_o, reset_on_timeout_o;
  logic             timeout_flag_o, timeout_irq_flag_o, running_o, chip_reset_o;
  mode_t            mode_wdata_i;
  logic [7:0]       feed_wdata_i;
  logic [CNT_W-1:0] tc_wdata_i, timeout_constant_o, count_readback_o;
  int               err_total, compares, ticks, t0;
  count_clock_src count_clock_src_i (.clk_i, .srst_i, .tick_o(count_tick_i));
  watchdog_timer watchdog_timer_i (.clk_i, .srst_i, .count_tick_i, .mode_wr_i, .mode_wdata_i, .tc_wr_i,
    .tc_wdata_i, .feed_wr_i, .feed_wdata_i, .other_access_i, .timeout_flag_clr_i, .run_enable_o,
    .reset_on_timeout_o, .timeout_constant_o, .count_readback_o, .timeout_flag_o, .timeout_irq_flag_o,
    .running_o, .chip_reset_o);
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (count_tick_i === 1'b1) ticks <= ticks + 1;
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr_tc(input logic [31:0] d);
    tc_wr_i = 1'b1;
    tc_wdata_i = d;
    step(1);
    tc_wr_i = 1'b0;
  endtask
  task automatic wr_mode(input mode_t m);
    mode_wr_i = 1'b1;
    mode_wdata_i = m;
    step(1);
    mode_wr_i = 1'b0;
  endtask
  task automatic clr_tof;
    timeout_flag_clr_i = 1'b1;
    step(1);
    timeout_flag_clr_i = 1'b0;
  endtask
  task automatic feed;
    feed_wr_i = 1'b1;
    feed_wdata_i = FEED_FIRST;
    step(1);
    feed_wdata_i = FEED_SECOND;
    step(1);
    feed_wr_i = 1'b0;
    t0 = ticks;
  endtask
  // first feed byte, then one wrong access of kind k
  task automatic abort(input int k);
    feed_wr_i = 1'b1;
    feed_wdata_i = FEED_FIRST;
    step(1);
    feed_wr_i = (k == 1);
    feed_wdata_i = 8'h11;
    other_access_i = (k == 0);
    mode_wr_i = (k == 2);
    tc_wr_i = (k == 3);
    step(1);
    {feed_wr_i, other_access_i, mode_wr_i, tc_wr_i} = 4'h0;
  endtask
  // bounded wait for the watchdog to stop
  task automatic wait_down;
    for (int n = 0; n < 5000 && running_o === 1'b1; n++) step(1);
    if (running_o !== 1'b0) begin
      err_total++;
      end_of_test();
    end
  endtask
  initial begin
    {srst_i, mode_wr_i, tc_wr_i, feed_wr_i, other_access_i, timeout_flag_clr_i} = 6'h20;
    mode_wdata_i = MODE_RESET;
    feed_wdata_i = 8'h00;
    tc_wdata_i = 32'h0;
    step(5);
    srst_i = 1'b0;
    check("tc_reset", timeout_constant_o, TC_RESET);
    check("rb_reset", count_readback_o, COUNT_RESET);
    check("state_reset", {run_enable_o, running_o, timeout_irq_flag_o}, 32'h0);
    wr_tc(32'h10);
    check("tc_floor", timeout_constant_o, 32'hff);
    wr_tc(32'h100);
    check("tc_write", timeout_constant_o, 32'h100);
    wr_tc(32'h0);
    wr_mode(mode_t'(2'h1));
    step(16);
    abort(0);
    step(2);
    check("unarmed", {running_o, timeout_irq_flag_o, chip_reset_o}, 32'h0);
    wr_mode(MODE_RESET);
    check("run_set_only", run_enable_o, 32'h1);
    feed();
    check("armed", running_o, 32'h1);
    wait_down();
    check("interval", ticks - t0, 32'd1024);
    check("irq_mode", {timeout_irq_flag_o, timeout_flag_o, run_enable_o}, 32'h4);
    clr_tof();
    check("irq_kept", timeout_irq_flag_o, 32'h1);
    wr_mode(mode_t'(2'h3));
    step(16);
    feed();
    step(1500);
    check("readback", {count_readback_o[31:8], count_readback_o < 32'hff}, 32'h1);
    feed();
    wait_down();
    check("reload", ticks - t0, 32'd1024);
    check("chip_reset", {chip_reset_o, timeout_flag_o}, 32'h3);
    clr_tof();
    check("tof_clear", timeout_flag_o, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr_mode(mode_t'(2'h3));
      step(16);
      feed();
      abort(k);
      check("abort_wait", chip_reset_o, 32'h0);
      step(1);
      check("abort_fire", {chip_reset_o, running_o}, 32'h2);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
